// >>> dv/gpirq_chk.sv
// Assertions on the pin side of the GPIO interrupt block
module gpirq_chk (
   // Clock, reset and inputs
   input wire        clk_in, reset_in, reg_read_in, pci_enable_in, pci_inta_in, pci_request_in,
   // Outputs
   input wire [15:0] reg_rdata_out, gpio_pin_out, gpio_pin_oe_out,
   input wire        pci_reset_out, pci_clock_out, pci_grant_out, pci_idsel_out, pci_cbe3_out,
   input wire        serial2_ext_clock_out, nmi_event_out, software_irq_out, irq_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================================================
   // Properties
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (reset_in);
   sequence s_pulse;
      nmi_event_out ##1 !nmi_event_out;
   endsequence
   nmi_pulse_a: assert property (nmi_event_out |-> s_pulse) else $error("nmi pulse");
   nmi_unmask_a: assert property (nmi_event_out |-> ##[0:4] irq_out)
      else $error("nmi masked");
   reset_input_a: assert property ($fell(reset_in) |-> gpio_pin_oe_out == 16'h0000)
      else $error("pin driven after reset");
   pci_idle_a: assert property (!pci_enable_in |=> !(pci_reset_out | pci_clock_out
      | pci_grant_out | pci_idsel_out | pci_cbe3_out)) else $error("pci active");
   pci_input_a: assert property (pci_enable_in |=> !(gpio_pin_oe_out[15]
      | gpio_pin_oe_out[14] | gpio_pin_oe_out[12] | gpio_pin_oe_out[9]))
      else $error("pci input driven");
   pci_drive_a: assert property (pci_enable_in |=> gpio_pin_out[13] == $past(pci_inta_in)
      && gpio_pin_out[11] == $past(pci_request_in)) else $error("pci output");
   gp8_input_a: assert property (serial2_ext_clock_out |-> !gpio_pin_oe_out[8])
      else $error("clock pin driven");
   swirq_drive_a: assert property (software_irq_out |-> gpio_pin_oe_out[0])
      else $error("swirq not driven");
endmodule // gpirq_chk

// >>> dv/tb_top.sv
// Self-checking bench for the GPIO interrupt block
`include "gpirq_consts.vh"
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================================================
   // Stimulus and checks
   logic clk_in = 0, reset_in = 1, reg_write_in = 0, reg_read_in = 0, nmi_pin_in = 0;
   logic pci_enable_in = 0, pci_inta_in = 0, pci_request_in = 0;
   logic pci_cbe3_in = 0, pci_cbe3_oe_in = 0;
   logic [3:0]  reg_addr_in = 4'h0;
   logic [15:0] reg_wdata_in = 16'h0000, gpio_pin_in = 16'h0000;
   wire  [15:0] reg_rdata_out, gpio_pin_out, gpio_pin_oe_out;
   wire  pci_reset_out, pci_clock_out, pci_grant_out, pci_idsel_out, pci_cbe3_out;
   wire  serial2_ext_clock_out, nmi_event_out, software_irq_out, irq_out;
   int   mismatches = 0, checks_done = 0;
   always #5 clk_in = ~clk_in;
   gpirq_top i_dut (.clk_in, .reset_in, .reg_addr_in, .reg_wdata_in, .reg_write_in,
      .reg_read_in, .reg_rdata_out, .nmi_pin_in, .pci_enable_in, .gpio_pin_in, .gpio_pin_out,
      .gpio_pin_oe_out, .pci_reset_out, .pci_clock_out, .pci_grant_out, .pci_idsel_out,
      .pci_cbe3_out, .pci_inta_in, .pci_request_in, .pci_cbe3_in, .pci_cbe3_oe_in,
      .serial2_ext_clock_out, .nmi_event_out, .software_irq_out, .irq_out);
   function automatic logic hit(logic pv, logic lvl);
      return lvl != pv;
   endfunction
   task automatic chk(input logic ok);
      checks_done++;
      if (ok !== 1'b1) begin
         mismatches++;
         $display("Error %0t: unexpected value", $time);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk_in);
      reg_addr_in <= a;
      reg_wdata_in <= d;
      reg_write_in <= 1;
      @(posedge clk_in);
      reg_write_in <= 0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge clk_in);
      reg_addr_in <= a;
      reg_read_in <= 1;
      @(posedge clk_in);
      reg_read_in <= 0;
      #1 d = reg_rdata_out;
   endtask
   task automatic test_done;
      if (mismatches == 0 && checks_done > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   initial begin
      logic [15:0] d, g;
      logic [3:0]  pv, en, mk;
      logic        e;
      int          i, p;
      void'($urandom(26634));
      repeat (16) @(posedge clk_in);
      reset_in <= 0;
      rd(`GPIRQ_OFS_DIR, d);
      chk(d === `GPIRQ_RST_DIR && gpio_pin_oe_out === 16'h0000);
      rd(`GPIRQ_OFS_CTRL, d);
      chk(d === 16'h0000);
      rd(4'h8 + 4'($urandom_range(7)), d);
      chk(d === 16'h0000);
      g = 16'($urandom()) & 16'hFE00;
      gpio_pin_in <= g;
      cyc(6);
      chk({pci_reset_out, pci_clock_out, pci_grant_out, pci_idsel_out, pci_cbe3_out}
          === 5'h00);
      pci_enable_in <= 1;
      pci_inta_in <= 1;
      pci_request_in <= 1'($urandom());
      pci_cbe3_in <= 1'($urandom());
      pci_cbe3_oe_in <= 1'($urandom());
      cyc(6);
      chk({pci_reset_out, pci_clock_out, pci_grant_out, pci_idsel_out, pci_cbe3_out}
          === {g[15], g[14], g[12], g[9], g[10]});
      chk(gpio_pin_out[13] === 1'b1 && gpio_pin_out[11] === pci_request_in);
      chk(gpio_pin_out[10] === pci_cbe3_in && gpio_pin_oe_out[10] === pci_cbe3_oe_in);
      pci_enable_in <= 0;
      gpio_pin_in <= 16'h0100;
      for (i = 0; i < 3; i++) begin
         wr(`GPIRQ_OFS_CTRL, 16'h0008 | 16'(i));
         wr(`GPIRQ_OFS_OUT, 16'h0001);
         cyc(2);
         chk(gpio_pin_oe_out[0] === (i != 0) && software_irq_out === (i == 2));
      end
      wr(`GPIRQ_OFS_CTRL, 16'h0000);
      cyc(6);
      chk(serial2_ext_clock_out === 1'b1 && gpio_pin_oe_out[8] === 1'b0);
      wr(`GPIRQ_OFS_CTRL, 16'h0004);
      wr(`GPIRQ_OFS_DIR, 16'h0100);
      cyc(2);
      chk(serial2_ext_clock_out === 1'b0 && gpio_pin_oe_out[8] === 1'b1);
      wr(`GPIRQ_OFS_DIR, 16'h0000);
      for (i = 0; i < 40; i++) begin
         p = $urandom_range(7, 4);
         pv = 4'($urandom());
         en = 4'($urandom());
         mk = 4'($urandom());
         wr(`GPIRQ_OFS_POL, {12'h000, pv});
         wr(`GPIRQ_OFS_IRQ_EN, {8'h00, en, 4'h0});
         wr(`GPIRQ_OFS_MASK, {8'h00, mk, 4'h0});
         gpio_pin_in[p] <= ~gpio_pin_in[p];
         cyc(7);
         e = en[p-4] && hit(pv[p-4], gpio_pin_in[p]);
         chk(irq_out === (e && mk[p-4]));
         rd(`GPIRQ_OFS_STATUS, d);
         chk(d[p] === e);
         rd(`GPIRQ_OFS_STATUS, d);
         chk(d === 16'h0000);
      end
      wr(`GPIRQ_OFS_MASK, 16'h0000);
      nmi_pin_in <= 1;
      for (i = 0; i < 8 && nmi_event_out !== 1'b1; i++) cyc(1);
      chk(i < 8);
      cyc(2);
      chk(irq_out === 1'b1);
      rd(`GPIRQ_OFS_STATUS, d);
      chk(d[0] === 1'b1);
      nmi_pin_in <= 0;
      cyc(7);
      rd(`GPIRQ_OFS_STATUS, d);
      chk(d === 16'h0000 && irq_out === 1'b0);
      test_done;
   end
endmodule // tb_top
bind gpirq_top gpirq_chk i_chk (.clk_in, .reset_in, .reg_read_in, .pci_enable_in, .pci_inta_in,
   .pci_request_in, .reg_rdata_out, .gpio_pin_out, .gpio_pin_oe_out, .pci_reset_out,
   .pci_clock_out, .pci_grant_out, .pci_idsel_out, .pci_cbe3_out, .serial2_ext_clock_out,
   .nmi_event_out, .software_irq_out, .irq_out);

// >>> pkg/gpirq_consts.vh
// Offsets, field positions, GP0 modes and reset values for the GPIO interrupt pin block
`ifndef GPIRQ_CONSTS_VH
`define GPIRQ_CONSTS_VH

// ==========================================================================
// Register offsets (word addresses on the plain register port)
`define GPIRQ_ADDR_W           4
`define GPIRQ_OFS_DIR          4'h0
`define GPIRQ_OFS_OUT          4'h1
`define GPIRQ_OFS_IN           4'h2
`define GPIRQ_OFS_IRQ_EN       4'h3
`define GPIRQ_OFS_POL          4'h4
`define GPIRQ_OFS_STATUS       4'h5
`define GPIRQ_OFS_MASK         4'h6
`define GPIRQ_OFS_CTRL         4'h7

// ==========================================================================
// Field positions
`define GPIRQ_IRQ_EN_LSB       4
`define GPIRQ_POL_LSB          0
`define GPIRQ_STAT_NMI         0
`define GPIRQ_STAT_EXT_LSB     4
`define GPIRQ_CTRL_GP0_LSB     0
`define GPIRQ_CTRL_GP8_SEL     2
`define GPIRQ_CTRL_SWIRQ       3

// ==========================================================================
// GP0 modes
`define GPIRQ_GP0_INPUT        2'h0
`define GPIRQ_GP0_OUTPUT       2'h1
`define GPIRQ_GP0_SWIRQ        2'h2

// ==========================================================================
// Reset values
`define GPIRQ_RST_DIR          16'h0000
`define GPIRQ_RST_OUT          16'h0000
`define GPIRQ_RST_IRQ_EN       8'h00
`define GPIRQ_RST_POL          4'h0
`define GPIRQ_RST_MASK         8'h00
`define GPIRQ_RST_CTRL         4'h0

`endif

// >>> verilog/gpirq_top.v
// GPIO, external interrupt and NMI pin logic with a plain register port
// ==========================================================================
module gpirq_top (
   // Clock and reset
   input  wire        clk_in,
   input  wire        reset_in,
   // Register port
   input  wire [3:0]  reg_addr_in,
   input  wire [15:0] reg_wdata_in,
   input  wire        reg_write_in,
   input  wire        reg_read_in,
   output reg  [15:0] reg_rdata_out,
   // Pins
   input  wire        nmi_pin_in,
   input  wire        pci_enable_in,
   input  wire [15:0] gpio_pin_in,
   output reg  [15:0] gpio_pin_out,
   output reg  [15:0] gpio_pin_oe_out,
   // PCI side of the shared pins
   output reg         pci_reset_out,
   output reg         pci_clock_out,
   output reg         pci_grant_out,
   output reg         pci_idsel_out,
   output reg         pci_cbe3_out,
   input  wire        pci_inta_in,
   input  wire        pci_request_in,
   input  wire        pci_cbe3_in,
   input  wire        pci_cbe3_oe_in,
   // Serial port 2 clock and interrupts
   output reg         serial2_ext_clock_out,
   output reg         nmi_event_out,
   output reg         software_irq_out,
   output reg         irq_out
);

`include "gpirq_consts.vh"

   // ==========================================================================
   // Pin synchronisers: three stages, a change counts when stages 2 and 3 agree
   reg [16:0] sync1_reg;
   reg [16:0] sync2_reg;
   reg [16:0] sync3_reg;
   reg [16:0] stable_reg;
   wire [16:0] raw_pins = {nmi_pin_in, gpio_pin_in};
   wire [16:0] stable_next;

   genvar gi;
   generate
      for (gi = 0; gi < 17; gi = gi + 1) begin : g_sync
         assign stable_next[gi] = (sync2_reg[gi] == sync3_reg[gi]) ?
                                  sync3_reg[gi] : stable_reg[gi];
      end
   endgenerate

   always @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         sync1_reg  <= 17'h0_0000;
         sync2_reg  <= 17'h0_0000;
         sync3_reg  <= 17'h0_0000;
         stable_reg <= 17'h0_0000;
      end else begin
         sync1_reg  <= raw_pins;
         sync2_reg  <= sync1_reg;
         sync3_reg  <= sync2_reg;
         stable_reg <= stable_next;
      end
   end

   // ==========================================================================
   // Software registers
   reg [15:0] dir_reg;
   reg [15:0] out_reg;
   reg [7:0]  irq_en_reg;
   reg [3:0]  pol_reg;
   reg [7:0]  status_reg;
   reg [7:0]  mask_reg;
   reg [3:0]  ctrl_reg;

   wire [1:0] gp0_mode = ctrl_reg[`GPIRQ_CTRL_GP0_LSB +: 2];
   wire       gp8_sel  = ctrl_reg[`GPIRQ_CTRL_GP8_SEL];

   // ==========================================================================
   // Edge detection
   wire       nmi_rise = stable_next[16] & ~stable_reg[16];
   // Inverting by the polarity turns a falling edge into a rising one
   wire [3:0] ext_now  = stable_next[7:4] ^ pol_reg;
   wire [3:0] ext_old  = stable_reg[7:4] ^ pol_reg;
   // Polarity 0 rising, 1 falling; pins used as interrupts must be inputs
   wire [3:0] ext_edge = ext_now & ~ext_old &
                         irq_en_reg[`GPIRQ_IRQ_EN_LSB +: 4] & ~dir_reg[7:4];

   wire [7:0] events = {ext_edge, 3'h0, nmi_rise};
   wire       wr = reg_write_in;
   wire       status_rd = reg_read_in && (reg_addr_in == `GPIRQ_OFS_STATUS);

   always @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         dir_reg     <= `GPIRQ_RST_DIR;
         out_reg     <= `GPIRQ_RST_OUT;
         irq_en_reg  <= `GPIRQ_RST_IRQ_EN;
         pol_reg     <= `GPIRQ_RST_POL;
         status_reg  <= 8'h00;
         mask_reg    <= `GPIRQ_RST_MASK;
         ctrl_reg    <= `GPIRQ_RST_CTRL;
      end else begin
         if (wr && reg_addr_in == `GPIRQ_OFS_DIR)
            dir_reg <= reg_wdata_in;
         if (wr && reg_addr_in == `GPIRQ_OFS_OUT)
            out_reg <= reg_wdata_in;
         if (wr && reg_addr_in == `GPIRQ_OFS_IRQ_EN)
            irq_en_reg <= reg_wdata_in[7:0];
         if (wr && reg_addr_in == `GPIRQ_OFS_POL)
            pol_reg <= reg_wdata_in[3:0];
         if (wr && reg_addr_in == `GPIRQ_OFS_MASK)
            mask_reg <= reg_wdata_in[7:0];
         if (wr && reg_addr_in == `GPIRQ_OFS_CTRL)
            ctrl_reg <= reg_wdata_in[3:0];
         // Read clears, but a new event in the same cycle survives
         status_reg <= (status_rd ? 8'h00 : status_reg) | events;
      end
   end

   // ==========================================================================
   // Pin muxing
   reg [15:0] pin_out_next;
   reg [15:0] pin_oe_next;
   always @* begin
      pin_out_next = out_reg;
      pin_oe_next  = dir_reg;
      // Pins 7..4 and 3 plain GPIO; 2..1 not owned here
      pin_oe_next[2:1] = 2'h0;
      case (gp0_mode)
         `GPIRQ_GP0_INPUT: begin
            pin_oe_next[0] = 1'b0;
         end
         `GPIRQ_GP0_OUTPUT: begin
            pin_oe_next[0] = 1'b1;
         end
         `GPIRQ_GP0_SWIRQ: begin
            pin_oe_next[0]  = 1'b1;
            pin_out_next[0] = ctrl_reg[`GPIRQ_CTRL_SWIRQ];
         end
         default: begin
            pin_oe_next[0] = 1'b0;
         end
      endcase
      if (!gp8_sel)
         pin_oe_next[8] = 1'b0;
      if (pci_enable_in) begin
         pin_oe_next[15:9]  = 7'h00;
         pin_oe_next[13]    = 1'b1;
         pin_out_next[13]   = pci_inta_in;
         pin_oe_next[11]    = 1'b1;
         pin_out_next[11]   = pci_request_in;
         pin_oe_next[10]    = pci_cbe3_oe_in;
         pin_out_next[10]   = pci_cbe3_in;
      end
   end

   always @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         gpio_pin_out          <= 16'h0000;
         gpio_pin_oe_out       <= 16'h0000;
         pci_reset_out         <= 1'b0;
         pci_clock_out         <= 1'b0;
         pci_grant_out         <= 1'b0;
         pci_idsel_out         <= 1'b0;
         pci_cbe3_out          <= 1'b0;
         serial2_ext_clock_out <= 1'b0;
         nmi_event_out         <= 1'b0;
         software_irq_out      <= 1'b0;
         irq_out               <= 1'b0;
         reg_rdata_out         <= 16'h0000;
      end else begin
         gpio_pin_out    <= pin_out_next;
         gpio_pin_oe_out <= pin_oe_next;
         // PCI inputs held low unless PCI owns the pins
         pci_reset_out   <= pci_enable_in & stable_reg[15];
         pci_clock_out   <= pci_enable_in & stable_reg[14];
         pci_grant_out   <= pci_enable_in & stable_reg[12];
         pci_cbe3_out    <= pci_enable_in & stable_reg[10];
         pci_idsel_out   <= pci_enable_in & stable_reg[9];
         serial2_ext_clock_out <= ~gp8_sel & stable_reg[8];
         nmi_event_out    <= nmi_rise;
         software_irq_out <= (gp0_mode == `GPIRQ_GP0_SWIRQ) &
                             ctrl_reg[`GPIRQ_CTRL_SWIRQ];
         // NMI bit bypasses the mask
         irq_out <= |(status_reg & (mask_reg | 8'h01));
         reg_rdata_out <= 16'h0000;
         if (reg_read_in) begin
            case (reg_addr_in)
               `GPIRQ_OFS_DIR:    reg_rdata_out <= dir_reg;
               `GPIRQ_OFS_OUT:    reg_rdata_out <= out_reg;
               `GPIRQ_OFS_IN:     reg_rdata_out <= stable_reg[15:0];
               `GPIRQ_OFS_IRQ_EN: reg_rdata_out <= {8'h00, irq_en_reg};
               `GPIRQ_OFS_POL:    reg_rdata_out <= {12'h000, pol_reg};
               `GPIRQ_OFS_STATUS: reg_rdata_out <= {8'h00, status_reg};
               `GPIRQ_OFS_MASK:   reg_rdata_out <= {8'h00, mask_reg};
               `GPIRQ_OFS_CTRL:   reg_rdata_out <= {12'h000, ctrl_reg};
               default:           reg_rdata_out <= 16'h0000;
            endcase
         end
      end
   end

endmodule // gpirq_top
